// file: hw/e1tsb_pkg.sv
/*
  Package for the E1 transmit two-frame slip buffer of one framer channel:
  register indices, field positions, reset values and carrier types.
  Assumes an APB bus with 32-bit data, one register per aligned word.
*/
package e1tsb_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] E1TSB_IDX_TS0_ALIGN    = 10'h190;  // Frame 1 time slot 0
  localparam logic [9:0] E1TSB_IDX_SLOTS_ONE    = 10'h191;  // Frame 1 slots 1-31 start
  localparam logic [9:0] E1TSB_IDX_TS0_NONALIGN = 10'h1B0;  // Frame 2 time slot 0
  localparam logic [9:0] E1TSB_IDX_SLOTS_TWO    = 10'h1B1;  // Frame 2 slots 1-31 start
  localparam logic [9:0] E1TSB_IDX_BUF_LAST     = 10'h1CF;  // Last buffer location
  localparam logic [9:0] E1TSB_IDX_BIT_SELECT   = 10'h12C;  // Si / Sa select controls
  localparam logic [9:0] E1TSB_IDX_SLOT_EN0     = 10'h1E4;  // Enables, slots 7-1
  localparam logic [9:0] E1TSB_IDX_SLOT_EN3     = 10'h1E7;  // Enables, slots 31-24
  localparam logic [9:0] E1TSB_IDX_MODE         = 10'h1F0;  // System interface mode

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int         E1TSB_INTL_BIT      = 7;       // International bit select
  localparam logic [7:0] E1TSB_NAT_MASK      = 8'h1F;   // National bit selects 4-0
  localparam logic [7:0] E1TSB_SELECT_MASK   = 8'h9F;   // Implemented select bits
  localparam logic [7:0] E1TSB_EN0_MASK      = 8'hFE;   // Bit 0 of first enable reserved
  localparam int         E1TSB_MODE_BIT      = 0;       // 1 = data highway modes

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] E1TSB_SELECT_RESET  = 8'h9F;   // All overhead bits pass
  localparam logic [7:0] E1TSB_SLOT_EN_RESET = 8'h00;   // Slots 1-31 frozen
  localparam logic       E1TSB_MODE_RESET    = 1'b0;    // Transmission mode

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic {
    E1TSB_MODE_TRANSMISSION,
    E1TSB_MODE_HIGHWAY
  } e1tsb_mode_type;

  // One byte offered by a system highway for a frame and time slot
  typedef struct packed {
    logic       valid;
    logic       frame;  // 0 = frame 1 (alignment), 1 = frame 2
    logic [4:0] slot;
    logic [7:0] data;
  } e1tsb_hw_byte_type;

  // Line-side read request
  typedef struct packed {
    logic       req;
    logic       frame;
    logic [4:0] slot;
  } e1tsb_line_req_type;

endpackage

// file: hw/e1tsb_slip_buffer.sv
/*
  Transmit two-frame slip buffer of one E1 framer channel, with its APB
  register slave. Both highways and the line reader run on pclk; their
  inputs come from logic in the same domain and are not synchronised.
*/
`timescale 1ns/1ps

module e1tsb_slip_buffer
  import e1tsb_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // System highways
  input  wire e1tsb_hw_byte_type  data_hw,
  input  wire e1tsb_hw_byte_type  sig_hw,
  // Transmit line read port
  input  wire e1tsb_line_req_type line_req,
  output logic      [7:0]         line_data,
  output logic                    line_valid
);

  // ----------------------------------------------------------------------
  // Storage and control registers
  // ----------------------------------------------------------------------
  logic [7:0]     buf_mem [0:63];   // 0: TS0 f1, 1-31 f1, 32: TS0 f2, 33-63 f2
  logic [7:0]     select_q;
  logic [31:0]    slot_en_q;        // Bit n enables time slot n
  e1tsb_mode_type mode_q;
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;
  logic [7:0]     line_data_q;
  logic           line_valid_q;

  // ----------------------------------------------------------------------
  // APB address decode
  // ----------------------------------------------------------------------
  wire logic [9:0] reg_idx    = paddr[11:2];
  wire logic       hit_buf    = (reg_idx >= E1TSB_IDX_TS0_ALIGN) &&
                                (reg_idx <= E1TSB_IDX_BUF_LAST);
  wire logic [5:0] buf_idx    = 6'(reg_idx - E1TSB_IDX_TS0_ALIGN);
  wire logic       hit_select = (reg_idx == E1TSB_IDX_BIT_SELECT);
  wire logic       hit_en     = (reg_idx >= E1TSB_IDX_SLOT_EN0) &&
                                (reg_idx <= E1TSB_IDX_SLOT_EN3);
  wire logic [1:0] en_grp     = 2'(reg_idx - E1TSB_IDX_SLOT_EN0);
  wire logic       hit_mode   = (reg_idx == E1TSB_IDX_MODE);
  wire logic       mapped     = hit_buf | hit_select | hit_en | hit_mode;
  wire logic       setup      = psel & ~penable;
  wire logic       access_end = psel & penable & pready_q;
  wire logic       wr_fire    = access_end & pwrite & mapped & pstrb[0];

  // Read data selection, reserved bits read as zero
  wire logic [7:0] en_byte    = slot_en_q[{en_grp, 3'b000} +: 8];
  wire logic [7:0] rd_byte    = hit_buf    ? buf_mem[buf_idx] :
                                hit_select ? select_q :
                                hit_en     ? en_byte :
                                hit_mode   ? {7'h00, mode_q == E1TSB_MODE_HIGHWAY} :
                                8'h00;

  // ----------------------------------------------------------------------
  // Highway write qualification
  // ----------------------------------------------------------------------
  wire logic       highway_md = (mode_q == E1TSB_MODE_HIGHWAY);
  // Slot 0 of either frame takes the highway selected by the mode
  wire logic       dh_ts0     = data_hw.valid & (data_hw.slot == 5'h00) & highway_md;
  wire logic       sh_ts0     = sig_hw.valid & (sig_hw.slot == 5'h00) & ~highway_md;
  // Slots 1-31 take the data highway only when enabled
  wire logic       dh_slot    = data_hw.valid & (data_hw.slot != 5'h00) &
                                slot_en_q[data_hw.slot];
  wire logic       hw_we      = dh_ts0 | sh_ts0 | dh_slot;
  wire logic       hw_frame   = dh_ts0 | dh_slot ? data_hw.frame : sig_hw.frame;
  wire logic [4:0] hw_slot    = dh_ts0 | dh_slot ? data_hw.slot : sig_hw.slot;
  wire logic [7:0] hw_data    = dh_ts0 | dh_slot ? data_hw.data : sig_hw.data;
  wire logic [5:0] hw_idx     = {hw_frame, hw_slot};

  // Bits the highway may change: selects gate Si always, Sa only in frame 2
  wire logic [7:0] intl_mask  = {select_q[E1TSB_INTL_BIT], 7'h7F};
  wire logic [7:0] nat_mask   = ~E1TSB_NAT_MASK | (select_q & E1TSB_NAT_MASK);
  wire logic [7:0] ts0_mask   = hw_frame ? (intl_mask & nat_mask) : intl_mask;
  wire logic [7:0] hw_mask    = (hw_slot == 5'h00) ? ts0_mask : 8'hFF;

  // Frozen bits keep the processor byte when both write the same location
  wire logic       pw_buf     = wr_fire & hit_buf;
  wire logic       same_loc   = pw_buf & hw_we & (buf_idx == hw_idx);
  wire logic [7:0] hw_base    = same_loc ? pwdata[7:0] : buf_mem[hw_idx];
  wire logic [7:0] hw_merged  = (hw_data & hw_mask) | (hw_base & ~hw_mask);

  // Line read location
  wire logic [5:0] line_idx   = {line_req.frame, line_req.slot};

  // ----------------------------------------------------------------------
  // Buffer memory: processor write first, highway write overrides
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (pw_buf) begin
      buf_mem[buf_idx] <= pwdata[7:0];
    end
    if (hw_we) begin
      buf_mem[hw_idx] <= hw_merged;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_q  <= E1TSB_SELECT_RESET;
      slot_en_q <= {4{E1TSB_SLOT_EN_RESET}};
      mode_q    <= e1tsb_mode_type'(E1TSB_MODE_RESET);
    end else if (wr_fire) begin
      if (hit_select) begin
        select_q <= pwdata[7:0] & E1TSB_SELECT_MASK;
      end
      if (hit_en) begin
        slot_en_q[{en_grp, 3'b000} +: 8] <= (en_grp == 2'd0) ?
          (pwdata[7:0] & E1TSB_EN0_MASK) : pwdata[7:0];
      end
      if (hit_mode) begin
        mode_q <= e1tsb_mode_type'(pwdata[E1TSB_MODE_BIT]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: one wait state, data and error captured at setup
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Line read port: byte one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_data_q  <= 8'h00;
      line_valid_q <= 1'b0;
    end else begin
      line_valid_q <= line_req.req;
      if (line_req.req) begin
        line_data_q <= buf_mem[line_idx];
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign line_data  = line_data_q;
  assign line_valid = line_valid_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper: no processor write to the highway's location
  wire logic hw_alone = hw_we & ~same_loc;

  a_apb_one_wait: assert property (setup |=> pready_q ##1 !pready_q)
    else $error("APB answer not exactly one wait state");

  a_apb_unmapped: assert property (setup && !mapped |=> pslverr_q && pready_q)
    else $error("Unmapped access not flagged");

  a_buf_rd_write: assert property (
    pw_buf && !same_loc && !(hw_we && hw_idx == buf_idx) |=>
      buf_mem[$past(buf_idx)] == $past(pwdata[7:0]))
    else $error("Processor write not stored");

  a_slot_en_load: assert property (
    dh_slot && !same_loc |=> buf_mem[$past(hw_idx)] == $past(data_hw.data))
    else $error("Enabled slot not loaded from data highway");

  a_slot_frozen: assert property (
    data_hw.valid && data_hw.slot != 5'h00 && !slot_en_q[data_hw.slot] && !sh_ts0 &&
    !(pw_buf && buf_idx == {data_hw.frame, data_hw.slot}) |=>
      $stable(buf_mem[{data_hw.frame, data_hw.slot}]))
    else $error("Disabled slot changed by highway");

  a_intl_frozen: assert property (
    hw_alone && hw_slot == 5'h00 && !select_q[E1TSB_INTL_BIT] |=>
      buf_mem[$past(hw_idx)][7] == $past(buf_mem[hw_idx][7]))
    else $error("Frozen international bit changed");

  a_nat_frozen: assert property (
    hw_alone && hw_slot == 5'h00 && hw_frame |=>
      ((buf_mem[$past(hw_idx)] ^ $past(buf_mem[hw_idx])) &
       ~$past(select_q) & E1TSB_NAT_MASK) == 8'h00)
    else $error("Frozen national bit changed");

  a_ts0_source: assert property (
    sig_hw.valid && sig_hw.slot == 5'h00 && highway_md && !data_hw.valid && !pw_buf |=>
      $stable(buf_mem[{sig_hw.frame, 5'h00}]))
    else $error("Signaling highway wrote slot 0 in highway mode");

  a_ts0_sig_load: assert property (
    sh_ts0 && !data_hw.valid && !same_loc && select_q == E1TSB_SELECT_MASK |=>
      buf_mem[{$past(sig_hw.frame), 5'h00}] == $past(sig_hw.data))
    else $error("Slot 0 not loaded from signaling highway");

  a_hw_priority: assert property (
    same_loc && hw_slot != 5'h00 |=> buf_mem[$past(hw_idx)] == $past(hw_data))
    else $error("Processor write beat highway write");

  a_line_read: assert property (
    line_req.req |=> line_valid_q && line_data_q == $past(buf_mem[line_idx]))
    else $error("Line read data wrong");

  // ----------------------------------------------------------------------
  // Register bus, control register, slot 0 data highway and line port checks
  // ----------------------------------------------------------------------

  // APB answer flags and read data
  a_pready_pulse: assert property (pready_q |=> !pready_q)
    else $error("Ready held longer than one cycle");

  a_pready_cause: assert property (pready_q |-> $past(setup))
    else $error("Ready without a setup cycle");

  a_slverr_ready: assert property (pslverr_q |-> pready_q)
    else $error("Error flag without ready");

  a_mapped_no_err: assert property (setup && mapped |=> !pslverr_q)
    else $error("Mapped access flagged as error");

  a_rd_upper_zero: assert property (prdata_q[31:8] == 24'h00_0000)
    else $error("Read data upper bits not zero");

  a_rd_unmapped: assert property (setup && !pwrite && !mapped |=> prdata_q == 32'h0000_0000)
    else $error("Unmapped read data not zero");

  a_rd_buf_data: assert property (
    setup && !pwrite && hit_buf |=> prdata_q[7:0] == $past(buf_mem[buf_idx]))
    else $error("Buffer read data wrong");

  a_rd_mode_data: assert property (
    setup && !pwrite && hit_mode |=> prdata_q[0] == $past(mode_q == E1TSB_MODE_HIGHWAY))
    else $error("Mode read data wrong");

  a_rd_hold: assert property (!(setup && !pwrite) |=> $stable(prdata_q))
    else $error("Read data changed without a read");

  // Control register writes
  a_sel_write: assert property (
    wr_fire && hit_select |=>
      select_q == ($past(pwdata[7:0]) & E1TSB_SELECT_MASK))
    else $error("Select register write wrong");

  a_sel_resvd: assert property ((select_q & ~E1TSB_SELECT_MASK) == 8'h00)
    else $error("Reserved select bits set");

  a_sel_stable: assert property (!(wr_fire && hit_select) |=> $stable(select_q))
    else $error("Select register changed without a write");

  a_en0_write: assert property (
    wr_fire && hit_en && en_grp == 2'd0 |=>
      slot_en_q[7:0] == ($past(pwdata[7:0]) & E1TSB_EN0_MASK))
    else $error("First enable register write wrong");

  a_en_write: assert property (
    wr_fire && hit_en && en_grp != 2'd0 |=>
      slot_en_q[{$past(en_grp), 3'b000} +: 8] == $past(pwdata[7:0]))
    else $error("Enable register write wrong");

  a_en0_resvd: assert property (!slot_en_q[0])
    else $error("Reserved enable bit set");

  a_en_stable: assert property (!(wr_fire && hit_en) |=> $stable(slot_en_q))
    else $error("Enables changed without a write");

  a_mode_write: assert property (
    wr_fire && hit_mode |=>
      (mode_q == E1TSB_MODE_HIGHWAY) == $past(pwdata[E1TSB_MODE_BIT]))
    else $error("Mode register write wrong");

  a_mode_stable: assert property (!(wr_fire && hit_mode) |=> $stable(mode_q))
    else $error("Mode changed without a write");

  a_unmapped_drop: assert property (
    access_end && !mapped |=>
      $stable(select_q) && $stable(slot_en_q) && $stable(mode_q))
    else $error("Unmapped write changed a register");

  // Slot 0 from the data highway and the line port
  a_ts0_data_load: assert property (
    dh_ts0 && !same_loc && select_q == E1TSB_SELECT_MASK |=>
      buf_mem[$past(hw_idx)] == $past(data_hw.data))
    else $error("Slot 0 not loaded from data highway");

  a_line_pulse: assert property (!line_req.req |=> !line_valid_q)
    else $error("Line valid without a request");

  a_line_hold: assert property (!line_req.req |=> $stable(line_data_q))
    else $error("Line data changed without a request");

  c_nat_frozen: cover property (hw_alone && hw_frame && hw_slot == 5'h00 &&
                                (select_q & E1TSB_NAT_MASK) == 8'h00);

  c_apb_read: cover property (setup && !pwrite && hit_buf ##1 pready_q);
  c_frozen_slot: cover property (data_hw.valid && data_hw.slot != 5'h00 &&
                                 !slot_en_q[data_hw.slot]);
  c_same_loc: cover property (same_loc);
  c_highway_ts0: cover property (dh_ts0 && data_hw.frame);

endmodule

// file: verif/e1tsb_far_model.sv
/*
  Far-side model: data highway, signaling highway and line reader.
  Assumes a single pclk domain; the bench calls its tasks.
*/
`timescale 1ns/1ps

module e1tsb_far_model
  import e1tsb_pkg::*;
(
  // Clock
  input  wire logic               pclk,
  // Highways and line reader
  output e1tsb_hw_byte_type       data_hw,
  output e1tsb_hw_byte_type       sig_hw,
  output e1tsb_line_req_type      line_req,
  input  wire logic [7:0]         line_data,
  input  wire logic               line_valid
);
  // --------------------------------------------------------------------
  // Idle levels
  // --------------------------------------------------------------------
  initial begin
    data_hw  = '0;
    sig_hw   = '0;
    line_req = '0;
  end

  // One byte for one cycle; after it the data shows its inverse
  task automatic put(input logic sg, input logic [5:0] loc, input logic [7:0] d);
    e1tsb_hw_byte_type b;
    b = {1'b1, loc, d};
    @(posedge pclk);
    if (sg) sig_hw <= b;
    else data_hw <= b;
    b = {1'b0, loc, ~d};
    @(posedge pclk);
    if (sg) sig_hw <= b;
    else data_hw <= b;
  endtask

  // Read one location; the answer stands one cycle after the request
  task automatic fetch(input logic [5:0] loc, output logic [8:0] got);
    @(posedge pclk);
    line_req <= {1'b1, loc};
    @(posedge pclk);
    line_req.req <= 1'b0;
    @(posedge pclk);
    got = {line_valid, line_data};
  endtask
endmodule

// file: verif/tb.sv
/*
  Self-checking bench for the transmit slip buffer: APB master,
  far-side model, one task per scenario. Assumes pclk at 40 MHz.
*/
`timescale 1ns/1ps

module tb
  import e1tsb_pkg::*;
;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic               pclk       = 1'b0;
  logic               presetn    = 1'b0;
  logic               psel       = 1'b0;
  logic               penable    = 1'b0;
  logic               pwrite     = 1'b0;
  logic [11:0]        paddr      = '0;
  logic [31:0]        pwdata     = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  e1tsb_hw_byte_type  data_hw;
  e1tsb_hw_byte_type  sig_hw;
  e1tsb_line_req_type line_req;
  logic [7:0]         line_data;
  logic               line_valid;
  logic [31:0]        rdv;
  logic               errv;
  int                 error_cnt  = 0;
  int                 num_checks = 0;

  always #12.5 pclk = ~pclk;

  e1tsb_slip_buffer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_hw(data_hw), .sig_hw(sig_hw), .line_req(line_req),
    .line_data(line_data), .line_valid(line_valid));

  e1tsb_far_model far_u (.pclk(pclk), .data_hw(data_hw), .sig_hw(sig_hw),
    .line_req(line_req), .line_data(line_data), .line_valid(line_valid));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  function automatic logic [7:0] pat(input int i);
    return 8'h3C ^ i[7:0];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      wrap_up();
    end
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rdv);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    rchk("select reset", E1TSB_IDX_BIT_SELECT, E1TSB_SELECT_RESET);
    for (int i = 0; i < 4; i++) rchk("enable reset", E1TSB_IDX_SLOT_EN0 + 10'(i), 8'h00);
    rchk("mode reset", E1TSB_IDX_MODE, 8'h00);
    apb(1'b1, E1TSB_IDX_BIT_SELECT, 8'hFF);
    rchk("select reserved", E1TSB_IDX_BIT_SELECT, E1TSB_SELECT_MASK);
    apb(1'b0, 10'h000, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, errv});
    chk("unmapped data", 32'h0, rdv);
  endtask

  // Processor fills both frames, then reads back and the line reads out
  task automatic t_map();
    logic [8:0] got;
    for (int i = 0; i < 64; i++) apb(1'b1, E1TSB_IDX_TS0_ALIGN + 10'(i), pat(i));
    for (int i = 0; i < 64; i++) begin
      rchk("cpu location", E1TSB_IDX_TS0_ALIGN + 10'(i), pat(i));
      far_u.fetch(6'(i), got);
      chk("line byte", {23'h0, 1'b1, pat(i)}, {23'h0, got});
    end
  endtask

  // Slots 7 and 24 enabled, 6 and 31 left frozen
  task automatic t_enable();
    logic [5:0] loc [5] = '{6'd7, 6'd39, 6'd6, 6'd56, 6'd31};
    logic [7:0] exp;
    apb(1'b1, E1TSB_IDX_SLOT_EN0, 8'h80);
    apb(1'b1, E1TSB_IDX_SLOT_EN3, 8'h01);
    for (int k = 0; k < 5; k++) far_u.put(1'b0, loc[k], 8'hA0 + 8'(k));
    for (int k = 0; k < 5; k++) begin
      exp = (k == 2 || k == 4) ? pat(loc[k]) : 8'hA0 + 8'(k);
      rchk("slot enable", E1TSB_IDX_TS0_ALIGN + 10'(loc[k]), exp);
    end
  endtask

  // Highway and processor write slot 7 at the same edge
  task automatic t_clash();
    fork
      apb(1'b1, E1TSB_IDX_TS0_ALIGN + 10'd7, 8'h0F);
      begin
        @(posedge pclk);
        far_u.put(1'b0, 6'd7, 8'hC3);
      end
    join
    rchk("collision", E1TSB_IDX_TS0_ALIGN + 10'd7, 8'hC3);
  endtask

  // Slot 0 sources per mode, then frozen overhead bits
  task automatic t_ts0();
    far_u.put(1'b1, 6'd0, 8'h5A);
    far_u.put(1'b0, 6'd0, 8'hEE);
    far_u.put(1'b1, 6'd32, 8'h66);
    rchk("align ts0 signaling", E1TSB_IDX_TS0_ALIGN, 8'h5A);
    rchk("nonalign ts0 signaling", E1TSB_IDX_TS0_NONALIGN, 8'h66);
    apb(1'b1, E1TSB_IDX_MODE, 8'h01);
    far_u.put(1'b0, 6'd0, 8'h99);
    far_u.put(1'b1, 6'd0, 8'h11);
    far_u.put(1'b0, 6'd32, 8'h77);
    rchk("align ts0 data", E1TSB_IDX_TS0_ALIGN, 8'h99);
    rchk("nonalign ts0 data", E1TSB_IDX_TS0_NONALIGN, 8'h77);
    apb(1'b1, E1TSB_IDX_BIT_SELECT, 8'h00);
    far_u.put(1'b0, 6'd0, 8'h00);
    far_u.put(1'b0, 6'd32, 8'h88);
    rchk("international frozen", E1TSB_IDX_TS0_ALIGN, 8'h80);
    rchk("national frozen", E1TSB_IDX_TS0_NONALIGN, 8'h17);
    apb(1'b1, E1TSB_IDX_TS0_ALIGN, 8'h00);
    rchk("international by cpu", E1TSB_IDX_TS0_ALIGN, 8'h00);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_map();
    t_enable();
    t_clash();
    t_ts0();
    wrap_up();
  end
endmodule
